/* core/deflection_pkg.sv */
// Purpose: Shared constants, register map and state types of the deflection timing block.
// Assumes: APB register bus with 32-bit data; one word per register at byte address 4*index.
// Notes: The registers of the block are 16 bits wide and sit in the low half of each word.
//
// What this block does
// - Drive pulse high time comes from a six-bit width, usable 20 to 35, default 30.
// - With flyback drive bit set, drive stays high during flyback; clear by default.
// - Three-bit rate code picks line length, with counts for 27 and 32 MHz clocks.
// - Code 000 gives 864 or 1024 pixels per line and is the default.
// - Code 001 gives 768 or 912 pixels; code 010 gives 858 or 1024.
// - Code 100 gives 800 or 944 pixels per line.
// - Code 101 gives 720 or 852 pixels; code 110 gives 712 or 844.
// - Signed delays in pixel clocks, bits 15 to 1, place sync reference and flyback.
// - Third loop gain is nine bits, weight two to minus nine, default 102.
// - Second loop gain is nine bits in bits 14 to 6, default 184.
// - Vertical sync select 0 locks to incoming sync, 1 runs free; default locked.
// - Raster mode 0 same raster, 1 delays field 2, 2 delays field 1, 3 reserved.
// - Adaption on makes lines per field follow the input; off by default.
package deflection_pkg;

   localparam logic [8:0] IDX_HORIZ_CTRL = 9'h140;
   localparam logic [8:0] IDX_SYNC_DELAY = 9'h141;
   localparam logic [8:0] IDX_GAIN_A = 9'h142;
   localparam logic [8:0] IDX_FLY_DELAY = 9'h144;
   localparam logic [8:0] IDX_GAIN_B = 9'h145;
   localparam logic [8:0] IDX_TILT = 9'h14a;
   localparam logic [8:0] IDX_CURVE = 9'h14b;
   localparam logic [8:0] IDX_DRV_WIDTH = 9'h1d1;
   localparam logic [8:0] IDX_VS_SELECT = 9'h1e2;
   localparam logic [8:0] IDX_RASTER = 9'h1e3;
   localparam logic [8:0] IDX_ADAPT = 9'h1e8;
   localparam logic [8:0] IDX_PIX_RATE = 9'h1f0;
   localparam logic [8:0] IDX_STATUS = 9'h1f1;
   localparam logic [8:0] IDX_MEAS_LINES = 9'h1f2;

   localparam int HC_VGUARD = 1;
   localparam int HC_HGUARD = 2;
   localparam int HC_FLYBACK = 3;
   localparam int HC_RAMP = 4;
   localparam int HC_RATE_LSB = 5;
   localparam int GAIN_LSB = 6;
   localparam int SHAPE_LSB = 6;

   localparam logic [5:0] WIDTH_RST = 6'h1e;
   localparam logic [5:0] WIDTH_MIN = 6'h14;
   localparam logic [5:0] WIDTH_MAX = 6'h23;
   localparam logic [8:0] GAIN3_RST = 9'h066;
   localparam logic [8:0] GAIN2_RST = 9'h0b8;
   localparam logic [9:0] LINES_RST = 10'h138;
   localparam logic [6:0] FLYBACK_PIXELS = 7'h40;
   localparam logic [9:0] VSYNC_LINES = 10'h003;

   typedef struct packed {
      logic [8:0] third_loop_gain;
      logic [8:0] second_loop_gain;
   } loop_gains_t;

   typedef struct packed {
      logic [7:1] ctrl;
      logic [5:0] width;
      logic [14:0] sync_dly;
      logic [14:0] fly_dly;
      loop_gains_t gains;
      logic [9:0] tilt;
      logic [9:0] curve;
      logic vs_free;
      logic [1:0] raster;
      logic adapt;
      logic fast_clk;
      logic [31:0] rdata;
      logic err;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic vs_prev;
      logic [5:0] pulse_cnt;
      logic pulse_act;
      logic [6:0] fly_cnt;
      logic fly_act;
      logic [5:0] level;
      logic drive_on;
      logic htrip;
      logic [9:0] vcnt;
      logic [9:0] meas;
      logic field_b;
      logic hout;
      logic flyout;
      logic vsout;
      logic blank;
   } state_t;

   function automatic logic [10:0] line_pixels(input logic [2:0] code, input logic fast);
      logic [10:0] n;
      case (code)
         3'b001: n = fast ? 11'h390 : 11'h300;
         3'b010: n = fast ? 11'h400 : 11'h35a;
         3'b100: n = fast ? 11'h3b0 : 11'h320;
         3'b101: n = fast ? 11'h354 : 11'h2d0;
         3'b110: n = fast ? 11'h34c : 11'h2c8;
         default: n = fast ? 11'h400 : 11'h360;
      endcase
      return n;
   endfunction

endpackage

/* core/deflection_timing_control.sv */
// Purpose: Horizontal and vertical deflection timing with an APB register file.
// Assumes: i_clk is the pixel clock; fault and sync pins are asynchronous.
// Notes: APB answers in the access phase with no wait states.
//
// The APB slave port is this design's own decision.
module deflection_timing_control (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_vsync,
   input wire logic i_hguard_fault,
   input wire logic i_vguard_fault,
   output logic o_hdrive,
   output logic o_flyback,
   output logic o_vsync,
   output logic o_beam_blank,
   output logic o_field_delay,
   output logic [1:0] o_raster_write,
   output deflection_pkg::loop_gains_t o_loop_gains
);
   deflection_pkg::state_t q;
   deflection_pkg::state_t d;
   logic [10:0] line_len;
   logic [10:0] hcnt;
   logic hwrap;
   logic [10:0] sync_pos;
   logic [10:0] fly_pos;
   logic [5:0] eff_width;
   logic [8:0] idx;
   logic setup;
   logic access;
   logic wr;
   logic ramp_cmd;
   logic vs_rise;
   logic [9:0] lines_target;
   logic vwrap;

   function automatic logic [10:0] place(input logic [14:0] dly, input logic [10:0] len);
      logic [11:0] p;
      p = dly[14] ? {1'b0, len} + {dly[11:0]} : {1'b0, dly[10:0]};
      return p[10:0];
   endfunction

   assign line_len = deflection_pkg::line_pixels(q.ctrl[7:5], q.fast_clk);
   line_timer #(.W(11)) u_line (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_length(line_len),
      .o_count(hcnt),
      .o_wrap(hwrap)
   );

   assign idx = i_paddr[10:2];
   assign setup = i_psel && !i_penable;
   assign access = i_psel && i_penable;
   assign wr = access && i_pwrite && !q.err;
   assign o_pready = access;
   assign o_prdata = q.rdata;
   assign o_pslverr = access && q.err;
   assign ramp_cmd = wr && idx == deflection_pkg::IDX_HORIZ_CTRL
      && i_pwdata[deflection_pkg::HC_RAMP];
   assign vs_rise = q.sync2[0] && !q.vs_prev;
   assign sync_pos = place(q.sync_dly, line_len);
   assign fly_pos = place(q.fly_dly, line_len);
   assign lines_target = q.adapt && q.meas != '0 ? q.meas : deflection_pkg::LINES_RST;
   assign vwrap = hwrap && q.vcnt >= lines_target - 10'h001;

   always_comb begin
      // Usable width is held to its documented span.
      if (q.width < deflection_pkg::WIDTH_MIN) begin
         eff_width = deflection_pkg::WIDTH_MIN;
      end else if (q.width > deflection_pkg::WIDTH_MAX) begin
         eff_width = deflection_pkg::WIDTH_MAX;
      end else begin
         eff_width = q.width;
      end
   end

   always_comb begin
      d = q;
      d.sync1 = {i_vguard_fault, i_hguard_fault, i_vsync};
      d.sync2 = q.sync1;
      d.vs_prev = q.sync2[0];

      // Register reads and decode errors are prepared in the setup phase.
      if (setup) begin
         d.err = 1'b0;
         d.rdata = '0;
         if (i_paddr[1:0] != 2'b00 || i_paddr[11]) begin
            d.err = 1'b1;
         end else if (idx == deflection_pkg::IDX_HORIZ_CTRL) begin
            d.rdata[7:1] = q.ctrl;
         end else if (idx == deflection_pkg::IDX_SYNC_DELAY) begin
            d.rdata[15:1] = q.sync_dly;
         end else if (idx == deflection_pkg::IDX_GAIN_A) begin
            d.rdata[14:6] = q.gains.third_loop_gain;
         end else if (idx == deflection_pkg::IDX_FLY_DELAY) begin
            d.rdata[15:1] = q.fly_dly;
         end else if (idx == deflection_pkg::IDX_GAIN_B) begin
            d.rdata[14:6] = q.gains.second_loop_gain;
         end else if (idx == deflection_pkg::IDX_TILT) begin
            d.rdata[15:6] = q.tilt;
         end else if (idx == deflection_pkg::IDX_CURVE) begin
            d.rdata[15:6] = q.curve;
         end else if (idx == deflection_pkg::IDX_DRV_WIDTH) begin
            d.rdata[5:0] = q.width;
         end else if (idx == deflection_pkg::IDX_VS_SELECT) begin
            d.rdata[0] = q.vs_free;
         end else if (idx == deflection_pkg::IDX_RASTER) begin
            d.rdata[1:0] = q.raster;
         end else if (idx == deflection_pkg::IDX_ADAPT) begin
            d.rdata[0] = q.adapt;
         end else if (idx == deflection_pkg::IDX_PIX_RATE) begin
            d.rdata[0] = q.fast_clk;
         end else if (idx == deflection_pkg::IDX_STATUS) begin
            d.rdata[5:0] = {q.blank, q.field_b, q.htrip, q.level != q.width, q.drive_on, 1'b0};
            d.rdata[11:6] = q.level;
         end else if (idx == deflection_pkg::IDX_MEAS_LINES) begin
            d.rdata[9:0] = q.meas;
         end else begin
            d.err = 1'b1;
         end
      end

      if (wr) begin
         if (idx == deflection_pkg::IDX_HORIZ_CTRL) begin
            // The ramp bit is a command and never stays set.
            d.ctrl = i_pwdata[7:1];
            d.ctrl[deflection_pkg::HC_RAMP] = 1'b0;
         end else if (idx == deflection_pkg::IDX_SYNC_DELAY) begin
            d.sync_dly = i_pwdata[15:1];
         end else if (idx == deflection_pkg::IDX_GAIN_A) begin
            d.gains.third_loop_gain = i_pwdata[14:6];
         end else if (idx == deflection_pkg::IDX_FLY_DELAY) begin
            d.fly_dly = i_pwdata[15:1];
         end else if (idx == deflection_pkg::IDX_GAIN_B) begin
            d.gains.second_loop_gain = i_pwdata[14:6];
         end else if (idx == deflection_pkg::IDX_TILT) begin
            d.tilt = i_pwdata[15:6];
         end else if (idx == deflection_pkg::IDX_CURVE) begin
            d.curve = i_pwdata[15:6];
         end else if (idx == deflection_pkg::IDX_DRV_WIDTH) begin
            d.width = i_pwdata[5:0];
         end else if (idx == deflection_pkg::IDX_VS_SELECT) begin
            d.vs_free = i_pwdata[0];
         end else if (idx == deflection_pkg::IDX_RASTER) begin
            d.raster = i_pwdata[1:0];
         end else if (idx == deflection_pkg::IDX_ADAPT) begin
            d.adapt = i_pwdata[0];
         end else if (idx == deflection_pkg::IDX_PIX_RATE) begin
            d.fast_clk = i_pwdata[0];
         end
      end

      // Unless a horizontal guard fault trips the drive in the same cycle, a ramp command reverses the drive target and clears a horizontal trip.
      if (ramp_cmd) begin
         d.drive_on = !q.drive_on;
         d.htrip = 1'b0;
      end
      if (!q.ctrl[deflection_pkg::HC_HGUARD] && q.sync2[1]) begin
         d.htrip = 1'b1;
         d.drive_on = 1'b0;
         d.level = '0;
      end else if (hwrap) begin
         // One step per line toward the target width gives the soft start and stop.
         if (q.drive_on && q.level < eff_width) begin
            d.level = q.level + 6'h01;
         end else if (q.drive_on && q.level > eff_width) begin
            d.level = q.level - 6'h01;
         end else if (!q.drive_on && q.level != '0) begin
            d.level = q.level - 6'h01;
         end
      end

      if (hcnt == sync_pos) begin
         d.pulse_act = 1'b1;
         d.pulse_cnt = '0;
      end else if (q.pulse_act) begin
         d.pulse_cnt = q.pulse_cnt + 6'h01;
         d.pulse_act = q.pulse_cnt < 6'h3e;
      end
      if (hcnt == fly_pos) begin
         d.fly_act = 1'b1;
         d.fly_cnt = '0;
      end else if (q.fly_act) begin
         d.fly_cnt = q.fly_cnt + 7'h01;
         d.fly_act = q.fly_cnt < deflection_pkg::FLYBACK_PIXELS - 7'h01;
      end
      d.flyout = q.fly_act;
      d.hout = !q.htrip && q.level != '0 && ((q.pulse_act && q.pulse_cnt < q.level)
         || (q.fly_act && q.ctrl[deflection_pkg::HC_FLYBACK]));

      // Vertical timing: locked mode restarts the field on each incoming sync.
      if (vs_rise && !q.vs_free) begin
         // The count of line ends since the last restart is the field length.
         d.vcnt = '0;
         d.meas = q.vcnt;
         d.field_b = !q.field_b;
      end else if (vwrap) begin
         d.vcnt = '0;
         d.field_b = !q.field_b;
      end else if (hwrap) begin
         d.vcnt = q.vcnt + 10'h001;
      end
      if (vs_rise && q.vs_free) begin
         d.meas = q.vcnt;
      end
      d.vsout = q.vcnt < deflection_pkg::VSYNC_LINES;
      d.blank = !q.ctrl[deflection_pkg::HC_VGUARD] && q.sync2[2];
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
         q.width <= deflection_pkg::WIDTH_RST;
         q.gains.third_loop_gain <= deflection_pkg::GAIN3_RST;
         q.gains.second_loop_gain <= deflection_pkg::GAIN2_RST;
      end else begin
         q <= d;
      end
   end

   assign o_hdrive = q.hout;
   assign o_flyback = q.flyout;
   assign o_vsync = q.vsout;
   assign o_beam_blank = q.blank;
   assign o_loop_gains = q.gains;
   // Raster selection: mode 3 behaves as mode 0.
   assign o_raster_write = q.raster == 2'd1 ? 2'b01 : q.raster == 2'd2 ? 2'b10 : 2'b11;
   assign o_field_delay = q.raster == 2'd1 ? q.field_b : q.raster == 2'd2 && !q.field_b;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   a_level_bound: assert property (q.level <= deflection_pkg::WIDTH_MAX)
      else $error("Drive level above maximum width.");
   a_flyback_high: assert property (q.fly_act && q.ctrl[3] && q.level != '0 && !q.htrip
      |=> o_hdrive)
      else $error("Drive not held high during flyback.");
   a_wrap_zero: assert property (hwrap |=> hcnt == 11'h000)
      else $error("Line counter did not restart after wrap.");
   a_default_line: assert property (q.ctrl[7:5] == 3'b000 && !q.fast_clk && hcnt == 11'h35f
      |-> hwrap)
      else $error("Code 000 line is not 864 pixels.");
   a_code_one: assert property (q.ctrl[7:5] == 3'b001 && q.fast_clk && hcnt == 11'h38f
      |-> hwrap)
      else $error("Code 001 line is not 912 pixels.");
   a_code_four: assert property (q.ctrl[7:5] == 3'b100 && q.fast_clk && hcnt == 11'h3af
      |-> hwrap)
      else $error("Code 100 line is not 944 pixels.");
   a_code_six: assert property (q.ctrl[7:5] == 3'b110 && !q.fast_clk && hcnt == 11'h2c7
      |-> hwrap)
      else $error("Code 110 line is not 712 pixels.");
   a_drive_start: assert property (hcnt == sync_pos && q.level > 6'h01 && !q.htrip
      && !q.sync2[1] |-> ##2 o_hdrive)
      else $error("Drive pulse did not start at sync reference.");
   a_vsync_lock: assert property (vs_rise && !q.vs_free |=> q.vcnt == 10'h000)
      else $error("Field did not restart on incoming sync.");
   a_raster_a: assert property (q.raster == 2'd1 |-> o_raster_write == 2'b01)
      else $error("Raster mode 1 writes raster B.");
   a_trip_off: assert property (q.htrip |=> !o_hdrive)
      else $error("Drive active after horizontal trip.");
   a_ramp_flip: assert property (ramp_cmd && !q.sync2[1] |=> q.drive_on != $past(q.drive_on))
      else $error("Ramp command did not reverse drive target.");

   c_full_width: cover property (q.drive_on && q.level == eff_width);
   c_ramp_down: cover property (!q.drive_on && q.level == 6'h01);
   c_locked_field: cover property (vs_rise && !q.vs_free);
endmodule // deflection_timing_control

/* core/line_timer.sv */
// Purpose: Free-running pixel counter with a programmable line length.
// Assumes: Length changes take effect at once; a count past the new end wraps.
// Notes: The wrap pulse marks the last pixel of a line.
module line_timer #(
   parameter int W = 11
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_length,
   output logic [W-1:0] o_count,
   output logic o_wrap
);
   logic [W-1:0] count_q;
   logic [W-1:0] count_d;

   assign o_wrap = (count_q >= i_length - W'(1));
   assign o_count = count_q;

   always_comb begin
      count_d = o_wrap ? '0 : count_q + W'(1);
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end
endmodule // line_timer

/* testbench/crt_stage_model.sv */
// Purpose: Output stage stand-in that watches drive, flyback and vertical sync pins.
// Assumes: Pixel clock timing; incoming sync comes every VS_LINES lines while enabled.
// Notes: Reports pulse widths, line period and field length to the bench.
module crt_stage_model #(
   parameter int VS_LINES = 6
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_hdrive,
   input wire logic i_flyback,
   input wire logic i_vsync,
   input wire logic i_vs_en,
   output logic o_vsync_in,
   output int o_width,
   output int o_gap,
   output int o_period,
   output int o_lines,
   output int o_pulses,
   output int o_field,
   output int o_vrises
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hd_q, fb_q, vs_q;
   int run, since, in_field, vs_cnt;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         {hd_q, fb_q, vs_q, o_vsync_in} <= '0;
         {run, since, in_field, vs_cnt, o_width, o_gap, o_period} <= '0;
         {o_lines, o_pulses, o_field, o_vrises} <= '0;
      end else begin
         hd_q <= i_hdrive;
         fb_q <= i_flyback;
         vs_q <= i_vsync;
         run <= i_hdrive ? run + 1 : 0;
         since <= since + 1;
         if (hd_q && !i_hdrive) o_width <= run;
         if (i_hdrive && !hd_q) begin
            o_gap <= since;
            o_pulses <= o_pulses + 1;
         end
         if (i_flyback && !fb_q) begin
            since <= 1;
            o_period <= since;
            o_lines <= o_lines + 1;
            in_field <= in_field + 1;
            vs_cnt <= (vs_cnt >= VS_LINES - 1) ? 0 : vs_cnt + 1;
         end
         if (i_vsync && !vs_q) begin
            o_field <= in_field;
            in_field <= 0;
            o_vrises <= o_vrises + 1;
         end
         // Incoming sync stands for one whole line, once per field.
         o_vsync_in <= i_vs_en && vs_cnt == 0;
      end
   end
endmodule // crt_stage_model

/* testbench/deflection_timing_control_tb.sv */
// Purpose: Self-checking bench for the deflection timing block.
// Assumes: One APB transfer at a time; the output stage model sits on the far side.
// Notes: Line lengths are measured between flyback starts.
`define chk(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module deflection_timing_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [11:0] addr;
      logic wr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } row_t;
   localparam int VS_LINES = 6;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, vsync_in, hfault = 0, vfault = 0, vs_en = 1, err, fd;
   logic hdrive, flyback, vsync_out, blank, fdelay;
   logic [1:0] rwrite;
   deflection_pkg::loop_gains_t gains;
   int width, gap, period, lines, pulses, field, vrises, k, miscompares = 0, checked = 0;
   int slow[8] = '{864, 768, 858, 864, 800, 720, 712, 864};
   int fast[8] = '{1024, 912, 1024, 1024, 944, 852, 844, 1024};
   logic [1:0] rtab[4] = '{2'b11, 2'b01, 2'b10, 2'b11};
   row_t rows[14] = '{
      '{12'h500, 1'b0, 32'h0, 32'h0},
      '{12'h508, 1'b0, 32'h0, 32'h1980},
      '{12'h514, 1'b0, 32'h0, 32'h2e00},
      '{12'h744, 1'b0, 32'h0, 32'h1e},
      '{12'h528, 1'b0, 32'h0, 32'h0},
      '{12'h52c, 1'b0, 32'h0, 32'h0},
      '{12'h788, 1'b0, 32'h0, 32'h0},
      '{12'h78c, 1'b0, 32'h0, 32'h0},
      '{12'h7a0, 1'b0, 32'h0, 32'h0},
      '{12'h504, 1'b1, 32'hffff, 32'hfffe},
      '{12'h510, 1'b1, 32'h35, 32'h34},
      '{12'h508, 1'b1, 32'hffffffff, 32'h7fc0},
      '{12'h514, 1'b1, 32'h40, 32'h40},
      '{12'h500, 1'b1, 32'h1, 32'h0}
   };

   always #5 clk = ~clk;

   deflection_timing_control dut (
      .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_vsync(vsync_in), .i_hguard_fault(hfault),
      .i_vguard_fault(vfault), .o_hdrive(hdrive), .o_flyback(flyback), .o_vsync(vsync_out),
      .o_beam_blank(blank), .o_field_delay(fdelay), .o_raster_write(rwrite),
      .o_loop_gains(gains));

   crt_stage_model #(.VS_LINES(VS_LINES)) stage (
      .i_clk(clk), .i_rst(rst), .i_hdrive(hdrive), .i_flyback(flyback),
      .i_vsync(vsync_out), .i_vs_en(vs_en), .o_vsync_in(vsync_in), .o_width(width),
      .o_gap(gap), .o_period(period), .o_lines(lines), .o_pulses(pulses),
      .o_field(field), .o_vrises(vrises));

   task automatic tally_and_finish();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Leaves a free edge first so psel is never driven twice in one step.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         miscompares++;
         tally_and_finish();
      end
   endtask

   task automatic wait_lines(input int n);
      int t, c;
      t = lines + n;
      for (c = 0; c < 2000 * n && lines < t; c++) @(posedge clk);
      if (lines < t) begin
         miscompares++;
         tally_and_finish();
      end
   endtask

   initial begin
      repeat (10) @(posedge clk);
      `chk(rwrite, 2'b11)
      `chk(gains, {9'h066, 9'h0b8})
      `chk(hdrive, 1'b0)
      rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr) apb(rows[i].addr, 1'b1, rows[i].wdata);
         apb(rows[i].addr, 1'b0, '0);
         `chk(rd, rows[i].exp)
      end
      `chk(gains, {9'h1ff, 9'h001})
      apb(12'h600, 1'b1, 32'hffff);
      `chk(err, 1'b1)
      apb(12'h600, 1'b0, '0);
      `chk(rd, 32'h0)
      apb(12'h500, 1'b1, 32'h10);
      for (k = 0; k < 16; k++) begin
         apb(12'h7c0, 1'b1, 32'(k / 8));
         apb(12'h500, 1'b1, 32'(k % 8) << 5);
         wait_lines(2);
         `chk(period, (k < 8) ? slow[k] : fast[k % 8])
      end
      apb(12'h7c0, 1'b1, 32'h0);
      apb(12'h500, 1'b1, 32'hc0);
      wait_lines(14);
      `chk(field, VS_LINES)
      apb(12'h7c8, 1'b0, '0);
      `chk(rd, 32'(VS_LINES))
      apb(12'h7a0, 1'b1, 32'h1);
      vs_en <= 1'b0;
      wait_lines(14);
      `chk(field, VS_LINES)
      apb(12'h7a0, 1'b1, 32'h0);
      apb(12'h788, 1'b1, 32'h1);
      vs_en <= 1'b1;
      k = vrises;
      wait_lines(14);
      `chk(vrises, k)
      for (k = 0; k < 4; k++) begin
         apb(12'h78c, 1'b1, 32'(k));
         repeat (2) @(posedge clk);
         `chk(rwrite, rtab[k])
         if (k == 1) fd = fdelay;
         if (k == 2) `chk(fdelay, ~fd)
      end
      `chk(width, 30)
      apb(12'h744, 1'b1, 32'h3f);
      wait_lines(8);
      `chk(width, 35)
      apb(12'h744, 1'b1, 32'h10);
      wait_lines(18);
      `chk(width, 20)
      apb(12'h510, 1'b1, 32'h0);
      apb(12'h504, 1'b1, 32'h14);
      wait_lines(2);
      `chk(gap, 10)
      apb(12'h504, 1'b1, 32'hffec);
      wait_lines(2);
      `chk(gap, 702)
      apb(12'h504, 1'b1, 32'h0);
      apb(12'h510, 1'b1, 32'h190);
      apb(12'h500, 1'b1, 32'hc8);
      wait_lines(2);
      repeat (70) @(posedge clk);
      `chk(width, 64)
      apb(12'h500, 1'b1, 32'hc0);
      wait_lines(2);
      repeat (70) @(posedge clk);
      `chk(width, 20)
      apb(12'h500, 1'b1, 32'hc4);
      hfault <= 1'b1;
      repeat (4) @(posedge clk);
      hfault <= 1'b0;
      k = pulses;
      wait_lines(2);
      `chk(pulses > k, 1'b1)
      apb(12'h500, 1'b1, 32'hc0);
      hfault <= 1'b1;
      repeat (4) @(posedge clk);
      hfault <= 1'b0;
      repeat (4) @(posedge clk);
      k = pulses;
      wait_lines(2);
      `chk(pulses, k)
      vfault <= 1'b1;
      repeat (6) @(posedge clk);
      `chk(blank, 1'b1)
      apb(12'h500, 1'b1, 32'hc2);
      repeat (3) @(posedge clk);
      `chk(blank, 1'b0)
      tally_and_finish();
   end
endmodule // deflection_timing_control_tb
